// >>> logic/gate_volume.sv
// Record-path noise gate, stereo record volume and oversampling select.
// Assumes an Avalon-MM master, samples arriving with valid/ready, 100 MHz clock.
//
// Our own choice: register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - normal release 0.41ms/step doubling, codes C-F reserved
// - limiter release 0.082ms/step doubling to 168ms
// - high sample rates use normal release timing
// - normal attack 0.10ms/step doubling, B-F reserved
// - limiter attack 0.020ms/step doubling to 20.48ms
// - high sample rates use normal attack timing
// - gate triggers below 5-bit threshold level
// - action 00 freezes amplifier gain
// - action 01 mutes output at once
// - action 10 ramps gain to gate gain
// - gate acts only when enabled, off after reset
// - 8-bit volume, 00h mute, C0h unity
// - commit bit applies both volumes together
// - oversample bit picks 64x or 128x
// - 3-bit gate gain field sets target gain
module gate_volume #(
   parameter int sample_width = 24,
   parameter int clock_period_ns = 10, // Step timers divide the base times by this
   parameter int release_cycles_top = 84000000
) (
   // Clock, reset, enable
   input wire logic clk,
   input wire logic rst,
   input wire logic enable,
   // Avalon-MM slave
   input wire logic [7:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   input wire logic [3:0] byteenable,
   output logic [31:0] readdata,
   output logic waitrequest,
   // Level measurement, in 1.5 dB units above -76.5 dB
   input wire logic [5:0] input_level,
   // Sample stream in
   input wire gate_volume_pkg::sample_pair_type in_pair,
   input wire logic in_valid,
   output logic in_ready,
   // Sample stream out
   output gate_volume_pkg::sample_pair_type out_pair,
   output logic out_valid,
   input wire logic out_ready,
   // Analogue-side controls
   output logic [6:0] amplifier_gain,
   output logic oversample_high_select,
   output logic gate_triggered
);
   logic [15:0] gate_control; // Gate configuration
   logic [15:0] extra_settings_one; // Oversampling and spare bits
   logic [15:0] level_settings; // Style, target gain, level-control enables
   logic [2:0] rate_select; // Sample rate code
   logic [7:0] left_pending; // Written but not applied
   logic [7:0] right_pending;
   logic [7:0] left_record_gain; // Applied volumes
   logic [7:0] right_record_gain;
   logic access_done; // One wait state then answer
   logic [31:0] next_readdata;
   gate_volume_pkg::gate_state_type gate_state;
   logic [31:0] step_timer; // Cycles left in present step
   logic [31:0] step_length; // Cycles per 1.5 dB step
   logic [6:0] gain_target; // Gate gain in 0.75 dB units
   logic below_threshold;
   logic gate_active;
   logic normal_timing;
   logic mute_now;
   gate_volume_pkg::sample_pair_type scaled_pair;
   gate_volume_pkg::sample_pair_type buffer_out;
   logic buffer_valid;
   logic buffer_ready;
   logic [3:0] release_code;
   logic [3:0] attack_code;
   logic [6:0] gate_gain_code_scaled;
   logic ramp_action; // Gate fired with the ramp action chosen

   // Elaboration checks
   if (sample_width != 24)
      $error("sample_width must be 24");
   if (clock_period_ns < 1)
      $error("clock_period_ns must be positive");
   if (release_cycles_top < 1)
      $error("release_cycles_top must be positive");

   // Field picks
   assign release_code = gate_control[gate_volume_pkg::release_lsb +: 4];
   assign attack_code = gate_control[gate_volume_pkg::attack_lsb +: 4];

   // Bus answers after one wait state; unmapped reads give zero
   always_comb
   begin
      next_readdata = 32'h0000_0000;
      case (address)
         gate_volume_pkg::gate_control_index: next_readdata = {16'h0000, gate_control};
         gate_volume_pkg::left_record_volume_index: next_readdata = {24'h000000, left_pending};
         gate_volume_pkg::right_record_volume_index: next_readdata = {24'h000000, right_pending};
         gate_volume_pkg::extra_settings_one_index: next_readdata = {16'h0000, extra_settings_one};
         gate_volume_pkg::level_settings_index: next_readdata = {16'h0000, level_settings};
         gate_volume_pkg::rate_settings_index: next_readdata = {29'h00000000, rate_select};
         gate_volume_pkg::gate_status_index:
            next_readdata = {20'h00000, left_record_gain[0], 1'b0, gate_state, gate_triggered,
               amplifier_gain[6:2], 1'b0};
         default: next_readdata = 32'h0000_0000;
      endcase
   end

   // Handshake: waitrequest high until the answering cycle
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         access_done <= 1'b0;
         readdata <= 32'h0000_0000;
      end
      else if (enable)
      begin
         access_done <= (read || write) && !access_done;
         if (read && !access_done)
            readdata <= next_readdata;
      end
   end
   assign waitrequest = (read || write) && !access_done;

   // Configuration registers, written at the accepting edge
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         gate_control <= gate_volume_pkg::gate_control_reset;
         extra_settings_one <= gate_volume_pkg::extra_settings_reset;
         level_settings <= gate_volume_pkg::level_settings_reset;
         rate_select <= gate_volume_pkg::rate_reset;
      end
      else if (enable && write && access_done && byteenable[0])
      begin
         // Low byte enable alone writes the whole 16-bit field
         case (address)
            gate_volume_pkg::gate_control_index: gate_control <= writedata[15:0];
            gate_volume_pkg::extra_settings_one_index: extra_settings_one <= writedata[15:0];
            gate_volume_pkg::level_settings_index: level_settings <= writedata[15:0];
            gate_volume_pkg::rate_settings_index: rate_select <= writedata[2:0];
            default: ;
         endcase
      end
   end

   // Pending volumes and simultaneous commit
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         left_pending <= gate_volume_pkg::volume_reset;
         right_pending <= gate_volume_pkg::volume_reset;
         left_record_gain <= gate_volume_pkg::volume_reset;
         right_record_gain <= gate_volume_pkg::volume_reset;
      end
      else if (enable && write && access_done && byteenable[0])
      begin
         if (address == gate_volume_pkg::left_record_volume_index)
         begin
            left_pending <= writedata[7:0];
            if (writedata[gate_volume_pkg::commit_bit] && byteenable[1])
            begin
               left_record_gain <= writedata[7:0];
               right_record_gain <= right_pending;
            end
         end
         else if (address == gate_volume_pkg::right_record_volume_index)
         begin
            right_pending <= writedata[7:0];
            if (writedata[gate_volume_pkg::commit_bit] && byteenable[1])
            begin
               left_record_gain <= left_pending;
               right_record_gain <= writedata[7:0];
            end
         end
      end
   end

   // Oversampling ratio drive
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         oversample_high_select <= 1'b0;
      else if (enable)
         oversample_high_select <= extra_settings_one[gate_volume_pkg::oversample_bit];
   end

   // Threshold compare: code n is -76.5 + 1.5n dB
   assign below_threshold = input_level
      < {1'b0, gate_control[gate_volume_pkg::threshold_lsb +: 5]};
   assign gate_active = gate_control[gate_volume_pkg::gate_on_bit] && below_threshold;
   assign ramp_action = gate_active
      && gate_control[gate_volume_pkg::action_lsb +: 2] == gate_volume_pkg::action_ramp;

   // High rates force normal-style step timing
   assign normal_timing = !level_settings[gate_volume_pkg::style_bit]
      || (rate_select == gate_volume_pkg::rate_high);

   // Gate gain code in 0.75 dB units above -23.25 dB; code 0 sits 5.25 dB low
   assign gate_gain_code_scaled =
      7'(level_settings[gate_volume_pkg::target_gain_lsb +: 3]) * 7'h08;
   assign gain_target = (gate_gain_code_scaled == 7'h00) ? 7'h00
      : gate_gain_code_scaled - 7'h01;

   // Step length: base doubled per code, reserved codes clamp to the last
   always_comb
   begin
      step_length = 32'h0000_0001;
      if (gain_target > amplifier_gain)
      begin
         if (normal_timing)
            step_length = 32'(gate_volume_pkg::release_normal_ns / clock_period_ns)
               << ((release_code > gate_volume_pkg::release_last)
                  ? gate_volume_pkg::release_last : release_code);
         else
            step_length = 32'(gate_volume_pkg::release_limit_ns / clock_period_ns)
               << ((release_code > gate_volume_pkg::release_last)
                  ? gate_volume_pkg::release_last : release_code);
      end
      else
      begin
         if (normal_timing)
            step_length = 32'(gate_volume_pkg::attack_normal_ns / clock_period_ns)
               << ((attack_code > gate_volume_pkg::attack_last)
                  ? gate_volume_pkg::attack_last : attack_code);
         else
            step_length = 32'(gate_volume_pkg::attack_limit_ns / clock_period_ns)
               << ((attack_code > gate_volume_pkg::attack_last)
                  ? gate_volume_pkg::attack_last : attack_code);
      end
      if (step_length > 32'(release_cycles_top))
         step_length = 32'(release_cycles_top);
   end

   // Gate state and gain ramp, one 1.5 dB step per timer expiry
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         gate_state <= gate_volume_pkg::gate_idle;
         step_timer <= 32'h0000_0000;
         amplifier_gain <= gate_volume_pkg::gain_floor + 7'h1F;
         gate_triggered <= 1'b0;
         mute_now <= 1'b0;
      end
      else if (enable)
      begin
         gate_triggered <= gate_active;
         mute_now <= gate_active
            && gate_control[gate_volume_pkg::action_lsb +: 2] == gate_volume_pkg::action_mute;
         case (gate_state)
            gate_volume_pkg::gate_idle:
            begin
               // Hold and mute actions leave the gain where it is
               if (ramp_action)
               begin
                  gate_state <= gate_volume_pkg::gate_attack;
                  step_timer <= step_length;
               end
            end
            gate_volume_pkg::gate_attack:
            begin
               if (!ramp_action)
                  gate_state <= gate_volume_pkg::gate_idle;
               else if (step_timer > 32'h0000_0001)
                  step_timer <= step_timer - 32'h0000_0001;
               else if (amplifier_gain == gain_target)
                  gate_state <= gate_volume_pkg::gate_release;
               else
               begin
                  amplifier_gain <= (amplifier_gain > gain_target)
                     ? ((amplifier_gain - gain_target >= gate_volume_pkg::gain_step)
                        ? amplifier_gain - gate_volume_pkg::gain_step : gain_target)
                     : ((gain_target - amplifier_gain >= gate_volume_pkg::gain_step)
                        ? amplifier_gain + gate_volume_pkg::gain_step : gain_target);
                  step_timer <= step_length;
               end
            end
            gate_volume_pkg::gate_release:
            begin
               // Settled at target; leave when the gate opens
               if (!ramp_action)
                  gate_state <= gate_volume_pkg::gate_idle;
               else if (amplifier_gain != gain_target)
               begin
                  gate_state <= gate_volume_pkg::gate_attack;
                  step_timer <= step_length;
               end
            end
            default: gate_state <= gate_volume_pkg::gate_idle;
         endcase
      end
   end

   // Volume scale: code 0 mutes, C0h is exact unity, linear in code; loud codes may wrap
   function automatic logic [23:0] scale_sample(input logic [23:0] sample,
      input logic [7:0] gain, input logic silence);
      logic signed [33:0] product;
      product = 34'(signed'(sample)) * 34'(signed'({2'b00, gain}));
      if (silence || gain == 8'h00)
         scale_sample = 24'h000000;
      else
         scale_sample = 24'(product / 34'sd192);
   endfunction

   // Samples scaled as they enter the buffer
   assign scaled_pair.left = scale_sample(in_pair.left, left_record_gain, mute_now);
   assign scaled_pair.right = scale_sample(in_pair.right, right_record_gain, mute_now);

   pair_buffer #(
      .width(48)
   ) output_buffer (
      .clk(clk),
      .rst(rst),
      .enable(enable),
      .in_data(scaled_pair),
      .in_valid(in_valid),
      .in_ready(buffer_ready),
      .out_data(buffer_out),
      .out_valid(buffer_valid),
      .out_ready(out_ready || !out_valid)
   );

   // Registered output stage and back-pressure
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         out_pair <= '0;
         out_valid <= 1'b0;
      end
      else if (enable && (out_ready || !out_valid))
      begin
         out_pair <= buffer_out;
         out_valid <= buffer_valid;
      end
   end
   assign in_ready = buffer_ready;
endmodule
`default_nettype wire

// >>> logic/gate_volume_pkg.sv
// Shared constants and carrier types for the record-path gate and volume block.
// Assumes a 100 MHz system clock and an Avalon-MM register slave.
package gate_volume_pkg;
   // Register indexes (printed offsets, not multiples of four)
   localparam logic [7:0] gate_control_index = 8'h14;
   localparam logic [7:0] left_record_volume_index = 8'h15;
   localparam logic [7:0] right_record_volume_index = 8'h16;
   localparam logic [7:0] extra_settings_one_index = 8'h17;
   localparam logic [7:0] level_settings_index = 8'h13;
   localparam logic [7:0] rate_settings_index = 8'h1B;
   localparam logic [7:0] gate_status_index = 8'h20;
   // Register bit fields
   localparam int release_lsb = 12;
   localparam int attack_lsb = 8;
   localparam int threshold_lsb = 3;
   localparam int action_lsb = 1;
   localparam int gate_on_bit = 0;
   localparam int commit_bit = 8;
   localparam int oversample_bit = 5;
   localparam int style_bit = 8;
   localparam int target_gain_lsb = 10;
   localparam int left_level_bit = 0;
   localparam int right_level_bit = 1;
   localparam int rate_lsb = 0;
   // Reset values, and the high sample rate code
   localparam logic [15:0] gate_control_reset = 16'h3200;
   localparam logic [7:0] volume_reset = 8'hC0;
   localparam logic [15:0] extra_settings_reset = 16'h0100;
   localparam logic [15:0] level_settings_reset = 16'h1C00;
   localparam logic [2:0] rate_reset = 3'h0;
   localparam logic [2:0] rate_high = 3'h6;
   // Codes
   localparam logic [1:0] action_hold = 2'h0;
   localparam logic [1:0] action_mute = 2'h1;
   localparam logic [1:0] action_ramp = 2'h2;
   localparam logic [3:0] release_last = 4'hB;
   localparam logic [3:0] attack_last = 4'hA;
   localparam logic [7:0] volume_unity = 8'hC0;
   // Step time bases in ns, per 1.5 dB step, code 0000
   localparam int release_normal_ns = 410000;
   localparam int release_limit_ns = 82000;
   localparam int attack_normal_ns = 100000;
   localparam int attack_limit_ns = 20000;
   // Gain in 0.75 dB units; gate gain codes -23.25 then -18..+18 by 6 dB
   localparam logic [6:0] gain_floor = 7'h00;
   localparam logic [6:0] gain_step = 7'h02;
   // Sample carrier
   typedef struct packed {
      logic [23:0] left;
      logic [23:0] right;
   } sample_pair_type;
   typedef enum logic [2:0] {
      gate_idle = 3'b001,
      gate_attack = 3'b010,
      gate_release = 3'b100
   } gate_state_type;
endpackage

// >>> logic/pair_buffer.sv
// Two-entry valid/ready buffer for sample pairs.
// Assumes one clock, active-high asynchronous reset and a clock enable.
`timescale 1ns/1ps
`default_nettype none
module pair_buffer #(
   parameter int width = 48
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   input wire logic enable,
   // Fill side
   input wire logic [width-1:0] in_data,
   input wire logic in_valid,
   output logic in_ready,
   // Drain side
   output logic [width-1:0] out_data,
   output logic out_valid,
   input wire logic out_ready
);
   logic [width-1:0] store [2]; // Two slots
   logic write_ptr; // Next slot to fill
   logic read_ptr; // Next slot to drain
   logic [1:0] count; // Words held

   // Elaboration check
   if (width < 1)
      $error("width must be positive");

   // Honest full and empty
   assign in_ready = (count != 2'h2);
   assign out_valid = (count != 2'h0);
   assign out_data = store[read_ptr];

   // Slots and pointers
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         write_ptr <= 1'b0;
         read_ptr <= 1'b0;
         count <= 2'h0;
      end
      else if (enable)
      begin
         if (in_valid && in_ready)
         begin
            store[write_ptr] <= in_data;
            write_ptr <= ~write_ptr;
         end
         if (out_valid && out_ready)
            read_ptr <= ~read_ptr;
         count <= count + 2'((in_valid && in_ready) ? 1 : 0)
                  - 2'((out_valid && out_ready) ? 1 : 0);
      end
   end
endmodule
`default_nettype wire

// >>> testbench/gate_volume_monitor.sv
// Port-level checker for the record-path gate and volume block.
// Assumes single clock, async active-high reset, one wait state per access.
`timescale 1ns/1ps
`default_nettype none
module gate_volume_monitor (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Register bus
   input wire logic [7:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   input wire logic [3:0] byteenable,
   input wire logic waitrequest,
   // Gate and stream
   input wire logic [5:0] input_level,
   input wire gate_volume_pkg::sample_pair_type out_pair,
   input wire logic out_valid,
   input wire logic out_ready,
   input wire logic [6:0] amplifier_gain,
   input wire logic oversample_high_select,
   input wire logic gate_triggered
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // Shadow copies of accepted writes; outputs are judged against them
   logic on_shadow;
   logic [4:0] thr_shadow;
   logic [1:0] act_shadow;
   logic os_shadow;
   logic accept;
   assign accept = write && !waitrequest && byteenable[0];
   // Follow accepted writes to gate and extra settings
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         on_shadow <= 1'b0;
         thr_shadow <= 5'h00;
         act_shadow <= 2'h0;
         os_shadow <= 1'b0;
      end
      else if (accept && address == 8'h14)
      begin
         on_shadow <= writedata[0];
         thr_shadow <= writedata[7:3];
         act_shadow <= writedata[2:1];
      end
      else if (accept && address == 8'h17)
         os_shadow <= writedata[5];
   end
   a_bus_one_wait: assert property
      ((read || write) && !$past(read || write) |-> waitrequest ##1 !waitrequest)
      else $error("access did not take exactly one wait state");
   a_reset_state: assert property
      ($fell(rst) |-> amplifier_gain == 7'h1F && !gate_triggered && !oversample_high_select)
      else $error("outputs wrong after reset");
   a_gate_needs_on: assert property (!on_shadow [*3] |-> !gate_triggered)
      else $error("gate fired while switched off");
   a_gate_below: assert property
      ((on_shadow && input_level < {1'b0, thr_shadow}) [*3] |-> gate_triggered)
      else $error("gate missed a level below threshold");
   a_gate_above: assert property
      ((on_shadow && input_level >= {1'b0, thr_shadow}) [*3] |-> !gate_triggered)
      else $error("gate fired at or above threshold");
   a_oversample_follow: assert property
      ($stable(os_shadow) [*3] |-> oversample_high_select == os_shadow)
      else $error("oversample select differs from register");
   a_hold_freeze: assert property
      ((gate_triggered && act_shadow == gate_volume_pkg::action_hold) [*2] |=> $stable(amplifier_gain))
      else $error("gain moved in hold action");
   a_gain_step: assert property
      (!$stable(amplifier_gain) |-> (amplifier_gain > $past(amplifier_gain) ?
         amplifier_gain - $past(amplifier_gain) : $past(amplifier_gain) - amplifier_gain) <= 7'h02)
      else $error("gain jumped more than one step");
   a_gain_ceiling: assert property (amplifier_gain <= 7'h37)
      else $error("gain above the top gate gain");
   a_out_stands: assert property (out_valid && !out_ready |=> out_valid && $stable(out_pair))
      else $error("output word dropped during stall");
   // Main scenarios reached
   c_ramp: cover property (gate_triggered && act_shadow == 2'h2 && !$stable(amplifier_gain));
   c_stall: cover property ((out_valid && !out_ready) [*3]);
   c_commit: cover property (accept && address == 8'h16 && writedata[8]);
endmodule
bind gate_volume gate_volume_monitor gate_volume_monitor_i (
   .clk(clk), .rst(rst), .address(address), .read(read), .write(write),
   .writedata(writedata), .byteenable(byteenable), .waitrequest(waitrequest),
   .input_level(input_level), .out_pair(out_pair), .out_valid(out_valid),
   .out_ready(out_ready), .amplifier_gain(amplifier_gain),
   .oversample_high_select(oversample_high_select), .gate_triggered(gate_triggered)
);
`default_nettype wire

// >>> testbench/test_adc_noise_gate_and_volume.sv
// Self-checking bench: registers, gate actions, ramp timing, volume, stream.
// Assumes package, design and bound checker are compiled before it.
`timescale 1ns/1ps
`default_nettype none
`define CHECK(got, exp) \
   begin \
      total_checks++; \
      if ((got) !== (exp)) \
      begin \
         bad_count++; \
         $display("BAD %0t got %h exp %h", $time, got, exp); \
      end \
   end
module test_adc_noise_gate_and_volume;
   // Design ports; enable stays high, a stall is tested on the stream
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic enable = 1'b1;
   logic [7:0] address = 8'h00;
   logic read = 1'b0;
   logic write = 1'b0;
   logic [31:0] writedata = 32'h0;
   logic [3:0] byteenable = 4'h0;
   logic [31:0] readdata;
   logic waitrequest;
   logic [5:0] input_level = 6'h00;
   gate_volume_pkg::sample_pair_type in_pair = '0;
   logic in_valid = 1'b0;
   logic in_ready;
   gate_volume_pkg::sample_pair_type out_pair;
   gate_volume_pkg::sample_pair_type got_note;
   logic out_valid;
   logic out_ready = 1'b1;
   logic [6:0] amplifier_gain;
   logic oversample_high_select;
   logic gate_triggered;
   // Bookkeeping and expected state
   int bad_count = 0;
   int total_checks = 0;
   logic [31:0] seed = 32'h4FEE;
   logic stall_on = 1'b0;
   logic [2:0] cyc = 3'h0;
   logic left_zero = 1'b0;
   logic muted = 1'b0;
   gate_volume_pkg::sample_pair_type expq[$];
   always #5 clk = ~clk;
   gate_volume #(.release_cycles_top(1000), .clock_period_ns(10000)) gate_volume_i (
      .clk(clk), .rst(rst), .enable(enable), .address(address), .read(read),
      .write(write), .writedata(writedata), .byteenable(byteenable),
      .readdata(readdata), .waitrequest(waitrequest), .input_level(input_level),
      .in_pair(in_pair), .in_valid(in_valid), .in_ready(in_ready),
      .out_pair(out_pair), .out_valid(out_valid), .out_ready(out_ready),
      .amplifier_gain(amplifier_gain), .oversample_high_select(oversample_high_select),
      .gate_triggered(gate_triggered)
   );
   // Receiver takes one cycle in eight while stalling, so the buffer fills
   always @(posedge clk)
   begin
      cyc <= cyc + 3'h1;
      out_ready <= !stall_on || cyc == 3'h0;
   end
   // Oldest note against each word leaving; a word with no note is a fault
   always @(posedge clk)
   begin
      if (!rst && out_valid === 1'b1 && out_ready === 1'b1)
      begin
         if (expq.size() > 0)
         begin
            got_note = expq.pop_front();
            `CHECK(out_pair, got_note)
         end
         else
            `CHECK(out_valid, 1'b0)
      end
   end
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // One bus access; request held until waitrequest is seen low at an edge
   task automatic bus(input logic wr, input logic [7:0] a, input logic [15:0] d,
         input logic [3:0] be, output logic [31:0] q);
      int n;
      n = 0;
      address <= a;
      write <= wr;
      read <= !wr;
      writedata <= {16'h0000, d};
      byteenable <= be;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (waitrequest !== 1'b0 && n < 100);
      q = readdata;
      read <= 1'b0;
      write <= 1'b0;
      if (n >= 100)
         bad_count++;
      @(posedge clk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [15:0] exp, input logic [15:0] m);
      logic [31:0] q;
      bus(1'b0, a, 16'h0000, 4'hF, q);
      `CHECK(q[15:0] & m, exp)
   endtask
   // Random pairs in; each expected word noted as it is accepted
   task automatic send(input int n);
      gate_volume_pkg::sample_pair_type p;
      gate_volume_pkg::sample_pair_type e;
      for (int i = 0; i < n; i++)
      begin
         seed = lfsr(seed);
         p.left = seed[23:0];
         seed = lfsr(seed);
         p.right = seed[23:0];
         e.left = (muted || left_zero) ? 24'h000000 : p.left;
         e.right = muted ? 24'h000000 : p.right;
         in_pair <= p;
         in_valid <= 1'b1;
         do @(negedge clk); while (in_ready !== 1'b1);
         expq.push_back(e);
         @(posedge clk);
      end
      in_valid <= 1'b0;
      @(posedge clk);
   endtask
   task automatic drain();
      int n;
      n = 0;
      while ((expq.size() > 0 || out_valid !== 1'b0) && n < 2000)
      begin
         @(negedge clk);
         n++;
      end
      @(posedge clk);
   endtask
   // Gate ramp: time between two gain steps, then the final gain
   task automatic ramp(input logic [15:0] g, input logic [15:0] lv, input logic [2:0] r,
         input int gap, input logic [6:0] tgt);
      logic [31:0] q;
      logic [6:0] last;
      int n;
      bus(1'b1, 8'h1B, {13'h0000, r}, 4'hF, q);
      bus(1'b1, 8'h13, lv, 4'hF, q);
      bus(1'b1, 8'h14, g, 4'hF, q);
      repeat (2)
      begin
         last = amplifier_gain;
         n = 0;
         while (amplifier_gain === last && n < 5000)
         begin
            @(negedge clk);
            n++;
         end
      end
      `CHECK(n >= gap && n <= gap + 1, 1'b1)
      repeat (5 * gap + 10) @(negedge clk);
      `CHECK(amplifier_gain, tgt)
      @(posedge clk);
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // Main sequence
   initial
   begin
      logic [31:0] q;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      rd(8'h14, 16'h3200, 16'hFFFF);
      rd(8'h15, 16'h00C0, 16'h00FF);
      rd(8'h16, 16'h00C0, 16'h00FF);
      rd(8'h17, 16'h0100, 16'h0121);
      rd(8'h30, 16'h0000, 16'hFFFF);
      bus(1'b1, 8'h17, 16'h0120, 4'hE, q);
      rd(8'h17, 16'h0100, 16'h0120);
      bus(1'b1, 8'h17, 16'h0120, 4'hF, q);
      stall_on <= 1'b1;
      send(8);
      drain();
      `CHECK(oversample_high_select, 1'b1)
      bus(1'b1, 8'h15, 16'h0000, 4'hF, q);
      send(3);
      drain();
      rd(8'h15, 16'h0000, 16'h00FF);
      bus(1'b1, 8'h16, 16'h01C0, 4'hF, q);
      left_zero = 1'b1;
      send(3);
      drain();
      bus(1'b1, 8'h15, 16'h01C0, 4'hF, q);
      left_zero = 1'b0;
      bus(1'b1, 8'h14, 16'h00FB, 4'hF, q);
      repeat (4) @(posedge clk);
      `CHECK(gate_triggered, 1'b1)
      muted = 1'b1;
      send(3);
      drain();
      input_level <= 6'h1F;
      repeat (4) @(posedge clk);
      `CHECK(gate_triggered, 1'b0)
      muted = 1'b0;
      send(3);
      drain();
      input_level <= 6'h1E;
      bus(1'b1, 8'h14, 16'h00F9, 4'hF, q);
      repeat (50) @(posedge clk);
      `CHECK(amplifier_gain, 7'h1F)
      rd(8'h14, 16'h00F9, 16'hFFFF);
      ramp(16'h10FD, 16'h1400, 3'h0, 82, 7'h27);
      ramp(16'h00FD, 16'h1000, 3'h0, 10, 7'h1F);
      ramp(16'h10FD, 16'h1500, 3'h0, 16, 7'h27);
      ramp(16'h00FD, 16'h1100, 3'h0, 2, 7'h1F);
      ramp(16'h00FD, 16'h1500, 3'h6, 41, 7'h27);
      ramp(16'h00FD, 16'h1100, 3'h6, 10, 7'h1F);
      complete_run();
   end
   // Hang guard, well beyond the expected run length
   initial
   begin
      repeat (60000) @(posedge clk);
      bad_count++;
      complete_run();
   end
endmodule
`default_nettype wire
